// ---- src/timer_regs.svh ----
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_CFG 8'h00
`define OFS_AMR 8'h04
`define OFS_BMR 8'h08
`define OFS_CTL 8'h0C
`define OFS_IMR 8'h18
`define OFS_RIS 8'h1C
`define OFS_MIS 8'h20
`define OFS_ICR 8'h24
`define OFS_AILR 8'h28
`define OFS_BILR 8'h2C
`define OFS_AMATCH 8'h30
`define OFS_APR 8'h38
`define OFS_BPR 8'h3C
`define OFS_AR 8'h48
`define OFS_BR 8'h4C

// ----------------------------------------------------------------------
// Field positions and encodings
// ----------------------------------------------------------------------
`define CTL_A_EN 0
`define CTL_A_STALL 1
`define CTL_RTC_RUN 4
`define CTL_A_OTE 5
`define CTL_B_EN 8
`define CTL_B_STALL 9
`define CTL_B_OTE 13
`define IRQ_A_TO 0
`define IRQ_RTC 3
`define IRQ_B_TO 8
`define CFG_32BIT 3'h0
`define CFG_RTC 3'h1
`define CFG_16BIT 3'h4
`define MODE_ONESHOT 2'h1
`define MODE_PERIODIC 2'h2

// ----------------------------------------------------------------------
// Reset values, timing counts and bus answers
// ----------------------------------------------------------------------
`define CNT_RESET 16'hFFFF
`define ILR_RESET 16'hFFFF
`define PR_RESET 8'h00
`define RTC_LOAD 32'h0000_0001
`define RTC_ZERO 32'h0000_0000
`define RTC_DIV 32768
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- src/timer_pkg.sv ----
package timer_pkg;

  // --------------------------------------------------------------------
  // State of the timer block
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] cfg;
    logic [1:0] amode;
    logic [1:0] bmode;
    logic a_en;
    logic a_stall;
    logic rtc_run;
    logic a_ote;
    logic b_en;
    logic b_stall;
    logic b_ote;
    logic [15:0] ailr;
    logic [15:0] bilr;
    logic [15:0] acnt;
    logic [15:0] bcnt;
    logic [31:0] match;
    logic [7:0] apr;
    logic [7:0] bpr;
    logic [7:0] apre;
    logic [7:0] bpre;
    logic a_to_raw;
    logic b_to_raw;
    logic rtc_raw;
    logic a_to_mask;
    logic b_to_mask;
    logic rtc_mask;
    logic rtc_loaded;
    logic trig;
    logic aw_held;
    logic w_held;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } timer_state_s;

  // --------------------------------------------------------------------
  // State of the one-second divider
  // --------------------------------------------------------------------
  typedef struct packed {
    logic prev;
    logic [15:0] cnt;
    logic tick;
  } rtc_div_state_s;

endpackage

// ---- src/rtc_second_divider.sv ----
`include "timer_regs.svh"

module rtc_second_divider #(
  parameter int DIV = `RTC_DIV
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic slow_clk_level,
  output logic tick
);

  timer_pkg::rtc_div_state_s s_reg;
  timer_pkg::rtc_div_state_s s_next;

  // ----------------------------------------------------------------------
  // Edge counter
  // ----------------------------------------------------------------------
  // Rising edges of the slow clock are counted; every DIV-th edge gives a
  // one-cycle tick. Stopping the count resets the phase.
  always_comb begin
    s_next = s_reg;
    s_next.prev = slow_clk_level;
    s_next.tick = 1'b0;
    if (!run) begin
      s_next.cnt = 16'h0000;
    end else if (slow_clk_level && !s_reg.prev) begin
      if (s_reg.cnt == 16'(DIV - 1)) begin
        s_next.cnt = 16'h0000;
        s_next.tick = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt + 16'h0001;
      end
    end
  end

  // Register the whole state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick = s_reg.tick;

endmodule // rtc_second_divider

// ---- src/adc_trigger_merge.sv ----
module adc_trigger_merge #(
  parameter int PEERS = 2
) (
  input wire logic own_trigger,
  input wire logic [PEERS-1:0] peer_triggers,
  output logic adc_trigger
);

  // ----------------------------------------------------------------------
  // Trigger merge
  // ----------------------------------------------------------------------
  // Triggers of all timer blocks share one line, so only one should be armed.
  assign adc_trigger = own_trigger | (|peer_triggers);

endmodule // adc_trigger_merge

// ---- src/general_timer_block.sv ----
// Operation
// - Two 16-bit halves run alone or join as one 32-bit timer or clock.
// - Trigger outputs of all timer blocks are ORed into one trigger.
// - After reset the block is idle with control registers at defaults.
// - Reset sets counters and loads to 0xFFFF and prescales to 0x00.
// - Configuration 0 selects 32-bit one-shot/periodic, 1 selects clock.
// - 32-bit configurations act only as one timer; 16-bit halves are free.
// - In 32-bit modes a load write fills B load high, A load low.
// - In 32-bit modes a count read returns B count high, A low.
// - In 32-bit timer mode A mode chooses one-shot/periodic; B mode ignored.
// - Enabled counter counts down and reloads the cycle after zero.
// - One-shot stops at time-out clearing enable; periodic keeps counting.
// - Reaching zero sets the time-out raw flag until software clears it.
// - With time-out unmasked the masked flag follows the raw flag.
// - Converter trigger fires at time-out only when trigger enable set.
// - A load rewrite while running is taken as count next cycle.
// - With stall set the count holds while the debugger halts the CPU; here the clock run bit lifts this hold in every configuration.
// - Clock mode counts up, loaded with one when first selected.
// - A 32.768 kHz pin clock is divided to 1 Hz for counting.
// - Clock count equal to match rolls to zero and keeps running.
// - Clock match sets raw, masked flag and interrupt; clear bit clears.
// - Clock debug-run bit keeps counting through halts despite stall.
// - Configuration 0x4 splits the block into two separate 16-bit timers.
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`include "timer_regs.svh"

module general_timer_block #(
  parameter int PEERS = 2,
  parameter int RTC_DIV = `RTC_DIV
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic debug_halt,
  input wire logic capture_compare_pin_even,
  input wire logic [PEERS-1:0] adc_trigger_peers,
  output logic adc_trigger,
  output logic timer_irq
);

  timer_pkg::timer_state_s s_reg;
  timer_pkg::timer_state_s s_next;
  logic rtc_tick;
  logic is32;
  logic halted_a;
  logic halted_b;
  logic wr_do;
  logic a_set;
  logic b_set;
  logic rtc_set;
  logic [31:0] cnt32;
  logic [31:0] wval;
  logic [31:0] ctl_vec;
  logic [31:0] raw_vec;
  logic [31:0] mask_vec;
  logic [32:0] rd_word;
  logic [32:0] rd_ar;
  logic [24:0] a_step;
  logic [24:0] b_step;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Byte-lane merge of a write onto the current register value.
  function automatic logic [31:0] wmerge(input logic [31:0] old_val,
                                         input logic [31:0] new_val,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // One 16-bit half with prescaler: returns {time-out, count, prescale}.
  function automatic logic [24:0] half_step(input logic [15:0] cnt,
                                            input logic [7:0] pre,
                                            input logic [15:0] ilr,
                                            input logic [7:0] pr);
    if (pre != 8'h00) begin
      return {1'b0, cnt, pre - 8'h01};
    end else if (cnt == 16'h0000) begin
      return {1'b1, ilr, pr};
    end else begin
      return {1'b0, cnt - 16'h0001, pr};
    end
  endfunction

  // Register read mux: returns {address known, data}.
  function automatic logic [32:0] reg_read(input logic [7:0] addr);
    case (addr)
      `OFS_CFG: return {1'b1, 29'h0, s_reg.cfg};
      `OFS_AMR: return {1'b1, 30'h0, s_reg.amode};
      `OFS_BMR: return {1'b1, 30'h0, s_reg.bmode};
      `OFS_CTL: return {1'b1, ctl_vec};
      `OFS_IMR: return {1'b1, mask_vec};
      `OFS_RIS: return {1'b1, raw_vec};
      `OFS_MIS: return {1'b1, raw_vec & mask_vec};
      `OFS_ICR: return {1'b1, 32'h0};
      `OFS_AILR: return {1'b1, (is32 ? s_reg.bilr : 16'h0), s_reg.ailr};
      `OFS_BILR: return {1'b1, 16'h0, s_reg.bilr};
      `OFS_AMATCH: return {1'b1, s_reg.match};
      `OFS_APR: return {1'b1, 24'h0, s_reg.apr};
      `OFS_BPR: return {1'b1, 24'h0, s_reg.bpr};
      `OFS_AR: return {1'b1, (is32 ? cnt32 : {16'h0, s_reg.acnt})};
      `OFS_BR: return {1'b1, 16'h0, s_reg.bcnt};
      default: return {1'b0, 32'h0};
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Status views
  // ----------------------------------------------------------------------
  // The debug stall is overridden by the clock run bit so wall time keeps up.
  assign is32 = (s_reg.cfg != `CFG_16BIT);
  assign halted_a = debug_halt & s_reg.a_stall & ~s_reg.rtc_run;
  assign halted_b = debug_halt & s_reg.b_stall & ~s_reg.rtc_run;
  assign cnt32 = {s_reg.bcnt, s_reg.acnt};
  assign wr_do = s_reg.aw_held & s_reg.w_held & ~s_reg.bvalid;
  assign a_step = half_step(s_reg.acnt, s_reg.apre, s_reg.ailr, s_reg.apr);
  assign b_step = half_step(s_reg.bcnt, s_reg.bpre, s_reg.bilr, s_reg.bpr);

  // Packed views of control and flag bits.
  always_comb begin
    ctl_vec = 32'h0;
    raw_vec = 32'h0;
    mask_vec = 32'h0;
    ctl_vec[`CTL_A_EN] = s_reg.a_en;
    ctl_vec[`CTL_A_STALL] = s_reg.a_stall;
    ctl_vec[`CTL_RTC_RUN] = s_reg.rtc_run;
    ctl_vec[`CTL_A_OTE] = s_reg.a_ote;
    ctl_vec[`CTL_B_EN] = s_reg.b_en;
    ctl_vec[`CTL_B_STALL] = s_reg.b_stall;
    ctl_vec[`CTL_B_OTE] = s_reg.b_ote;
    raw_vec[`IRQ_A_TO] = s_reg.a_to_raw;
    raw_vec[`IRQ_RTC] = s_reg.rtc_raw;
    raw_vec[`IRQ_B_TO] = s_reg.b_to_raw;
    mask_vec[`IRQ_A_TO] = s_reg.a_to_mask;
    mask_vec[`IRQ_RTC] = s_reg.rtc_mask;
    mask_vec[`IRQ_B_TO] = s_reg.b_to_mask;
  end

  // ----------------------------------------------------------------------
  // Next state: counting, bus, flags
  // ----------------------------------------------------------------------
  // Counting is resolved first so that a software write in the same cycle
  // wins over it; flag sets are applied last so an event beats a clear.
  always_comb begin
    s_next = s_reg;
    a_set = 1'b0;
    b_set = 1'b0;
    rtc_set = 1'b0;
    s_next.trig = 1'b0;
    rd_word = reg_read(s_reg.awaddr);
    rd_ar = reg_read(araddr);
    wval = wmerge(rd_word[31:0], s_reg.wdata, s_reg.wstrb);
    case (s_reg.cfg)
      `CFG_32BIT: begin
        if (s_reg.a_en && !halted_a) begin
          if (cnt32 == 32'h0) begin
            {s_next.bcnt, s_next.acnt} = {s_reg.bilr, s_reg.ailr};
            a_set = 1'b1;
            s_next.a_en = (s_reg.amode != `MODE_ONESHOT);
          end else begin
            {s_next.bcnt, s_next.acnt} = cnt32 - 32'h1;
          end
        end
      end
      `CFG_RTC: begin
        if (s_reg.a_en && !halted_a && rtc_tick) begin
          if (cnt32 == s_reg.match) begin
            {s_next.bcnt, s_next.acnt} = `RTC_ZERO;
            rtc_set = 1'b1;
          end else begin
            {s_next.bcnt, s_next.acnt} = cnt32 + 32'h1;
          end
        end
      end
      `CFG_16BIT: begin
        if (s_reg.a_en && !halted_a) begin
          {a_set, s_next.acnt, s_next.apre} = a_step;
          if (a_step[24] && s_reg.amode == `MODE_ONESHOT) begin
            s_next.a_en = 1'b0;
          end
        end
        if (s_reg.b_en && !halted_b) begin
          {b_set, s_next.bcnt, s_next.bpre} = b_step;
          if (b_step[24] && s_reg.bmode == `MODE_ONESHOT) begin
            s_next.b_en = 1'b0;
          end
        end
      end
      default: begin
      end
    endcase
    // Trigger pulse on a time-out whose half allows it.
    s_next.trig = (a_set & s_reg.a_ote) | (b_set & s_reg.b_ote);
    // Address and data channels are taken independently.
    if (awvalid && !s_reg.aw_held) begin
      s_next.aw_held = 1'b1;
      s_next.awaddr = awaddr;
    end
    if (wvalid && !s_reg.w_held) begin
      s_next.w_held = 1'b1;
      s_next.wdata = wdata;
      s_next.wstrb = wstrb;
    end
    if (s_reg.bvalid && bready) begin
      s_next.bvalid = 1'b0;
    end
    if (wr_do) begin
      s_next.aw_held = 1'b0;
      s_next.w_held = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = rd_word[32] ? `RESP_OKAY : `RESP_SLVERR;
      case (s_reg.awaddr)
        `OFS_CFG: begin
          s_next.cfg = wval[2:0];
          if (wval[2:0] == `CFG_RTC && !s_reg.rtc_loaded) begin
            {s_next.bcnt, s_next.acnt} = `RTC_LOAD;
            s_next.rtc_loaded = 1'b1;
          end
        end
        `OFS_AMR: s_next.amode = wval[1:0];
        `OFS_BMR: s_next.bmode = wval[1:0];
        `OFS_CTL: begin
          s_next.a_en = wval[`CTL_A_EN];
          s_next.a_stall = wval[`CTL_A_STALL];
          s_next.rtc_run = wval[`CTL_RTC_RUN];
          s_next.a_ote = wval[`CTL_A_OTE];
          s_next.b_en = wval[`CTL_B_EN];
          s_next.b_stall = wval[`CTL_B_STALL];
          s_next.b_ote = wval[`CTL_B_OTE];
        end
        `OFS_IMR: begin
          s_next.a_to_mask = wval[`IRQ_A_TO];
          s_next.rtc_mask = wval[`IRQ_RTC];
          s_next.b_to_mask = wval[`IRQ_B_TO];
        end
        `OFS_ICR: begin
          s_next.a_to_raw = s_reg.a_to_raw & ~wval[`IRQ_A_TO];
          s_next.rtc_raw = s_reg.rtc_raw & ~wval[`IRQ_RTC];
          s_next.b_to_raw = s_reg.b_to_raw & ~wval[`IRQ_B_TO];
        end
        `OFS_AILR: begin
          s_next.ailr = wval[15:0];
          if (is32) begin
            s_next.bilr = wval[31:16];
          end
          if (s_reg.a_en && is32) begin
            {s_next.bcnt, s_next.acnt} = wval;
          end else if (s_reg.a_en) begin
            s_next.acnt = wval[15:0];
          end
        end
        `OFS_BILR: begin
          s_next.bilr = wval[15:0];
          if (s_reg.b_en && !is32) begin
            s_next.bcnt = wval[15:0];
          end
        end
        `OFS_AMATCH: s_next.match = wval;
        `OFS_APR: s_next.apr = wval[7:0];
        `OFS_BPR: s_next.bpr = wval[7:0];
        default: begin
        end
      endcase
    end
    // Hardware events win over a clear in the same cycle.
    s_next.a_to_raw = s_next.a_to_raw | a_set;
    s_next.b_to_raw = s_next.b_to_raw | b_set;
    s_next.rtc_raw = s_next.rtc_raw | rtc_set;
    // Read channel answers one cycle after the address is taken.
    if (s_reg.rvalid && rready) begin
      s_next.rvalid = 1'b0;
    end
    if (arvalid && !s_reg.rvalid) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = rd_ar[31:0];
      s_next.rresp = rd_ar[32] ? `RESP_OKAY : `RESP_SLVERR;
    end
  end

  // Register the whole state; reset leaves the block idle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.acnt <= `CNT_RESET;
      s_reg.bcnt <= `CNT_RESET;
      s_reg.ailr <= `ILR_RESET;
      s_reg.bilr <= `ILR_RESET;
      s_reg.apr <= `PR_RESET;
      s_reg.bpr <= `PR_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------------
  // Sub-blocks and outputs
  // ----------------------------------------------------------------------
  rtc_second_divider #(.DIV(RTC_DIV)) u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(s_reg.a_en && s_reg.cfg == `CFG_RTC),
    .slow_clk_level(capture_compare_pin_even),
    .tick(rtc_tick)
  );

  adc_trigger_merge #(.PEERS(PEERS)) u_trig (
    .own_trigger(s_reg.trig),
    .peer_triggers(adc_trigger_peers),
    .adc_trigger(adc_trigger)
  );

  assign awready = ~s_reg.aw_held;
  assign wready = ~s_reg.w_held;
  assign bvalid = s_reg.bvalid;
  assign bresp = s_reg.bresp;
  assign arready = ~s_reg.rvalid;
  assign rvalid = s_reg.rvalid;
  assign rdata = s_reg.rdata;
  assign rresp = s_reg.rresp;
  assign timer_irq = |(raw_vec & mask_vec);

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  AST_RESET_VALUES: assert property (@(posedge aclk)
    !aresetn |=> (cnt32 == 32'hFFFF_FFFF && s_reg.ailr == 16'hFFFF
                  && s_reg.apr == 8'h00 && !s_reg.a_en))
    else $error("Reset values wrong.");
  AST_RELOAD: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_reg.cfg == `CFG_32BIT && s_reg.a_en && !halted_a && cnt32 == 32'h0
     && !wr_do) |=> cnt32 == $past({s_reg.bilr, s_reg.ailr}))
    else $error("No reload after zero.");
  AST_ONESHOT_STOP: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (s_reg.cfg == `CFG_32BIT && s_reg.a_en && !halted_a && cnt32 == 32'h0
     && s_reg.amode == `MODE_ONESHOT && !wr_do) |=> !s_reg.a_en [*2])
    else $error("One-shot did not stop.");
  AST_TIMEOUT_RAW: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (s_reg.cfg == `CFG_32BIT && s_reg.a_en && !halted_a && cnt32 == 32'h0)
    |=> s_reg.a_to_raw)
    else $error("Time-out flag not set.");
  AST_MASKED: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_reg.a_to_raw && s_reg.a_to_mask) |-> timer_irq)
    else $error("Masked time-out missing.");
  AST_TRIGGER: assert property (@(posedge aclk) disable iff (!aresetn)
    s_reg.trig |-> $past(s_reg.a_ote || s_reg.b_ote) && adc_trigger)
    else $error("Trigger without enable.");
  AST_STALL: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_reg.cfg == `CFG_32BIT && s_reg.a_en && halted_a && !wr_do)
    |=> $stable(cnt32))
    else $error("Count moved while stalled.");
  AST_RTC_ROLL: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_reg.cfg == `CFG_RTC && s_reg.a_en && !halted_a && rtc_tick
     && cnt32 == s_reg.match && !wr_do) |=> (cnt32 == 32'h0 && s_reg.rtc_raw))
    else $error("Clock did not roll over.");
  AST_RTC_DEBUG_RUN: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (s_reg.cfg == `CFG_RTC && s_reg.a_en && s_reg.rtc_run && rtc_tick
     && cnt32 != s_reg.match && !wr_do) |=> cnt32 == $past(cnt32) + 32'h1)
    else $error("Clock stalled in debug.");
  AST_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_do && s_reg.awaddr == `OFS_ICR && wval[`IRQ_RTC] && !rtc_set)
    |=> !s_reg.rtc_raw)
    else $error("Clear did not clear.");

endmodule // general_timer_block

// ---- test/rtc_crystal_model.sv ----
// 32.768 kHz source on the even capture pin; it toggles only while run is high.
module rtc_crystal_model (
  input wire logic run,
  output logic slow_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  // Half period of the crystal; it rests low while not powered.
  initial begin
    slow_clk = 1'b0;
    forever begin
      #15258.789 slow_clk = run ? ~slow_clk : 1'b0;
    end
  end
endmodule // rtc_crystal_model

// ---- test/general_timer_block_tb_top.sv ----
`include "timer_regs.svh"

module general_timer_block_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, debug_halt;
  logic adc_trigger, timer_irq, slow_clk, slow_run, seen;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, peers, resp;
  int fail_count, check_count, n;
  integer seed = 88;

  general_timer_block #(.PEERS(2), .RTC_DIV(4)) general_timer_block_i (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .debug_halt(debug_halt), .capture_compare_pin_even(slow_clk),
    .adc_trigger_peers(peers), .adc_trigger(adc_trigger),
    .timer_irq(timer_irq));

  rtc_crystal_model rtc_crystal_model_i (.run(slow_run), .slow_clk(slow_clk));

  // Clock of 100 MHz.
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ------------------------------------------------------------------
  // Bus and checking tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h want %h", $time, got, exp);
    end
  endtask

  // Readys are taken mid-cycle; all changes land on rising edges.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok, b_ok;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      aw_ok = awvalid && awready;
      w_ok = wvalid && wready;
      b_ok = bvalid;
      resp = bresp;
      @(posedge aclk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end while (!b_ok);
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp);
    logic ar_ok, got;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ar_ok = arvalid && arready;
      got = rvalid;
      rd = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ar_ok) arvalid <= 1'b0;
    end while (!got);
    rready <= 1'b0;
    @(posedge aclk);
    chk(rd, exp);
  endtask

  // Watches a window for any trigger pulse.
  task automatic watch_trig(input int lim);
    seen = 1'b0;
    repeat (lim) begin
      @(negedge aclk);
      if (adc_trigger) seen = 1'b1;
    end
    @(posedge aclk);
  endtask

  function automatic logic [31:0] join_halves(logic [15:0] hi, lo);
    return {hi, lo};
  endfunction

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // A hang counts as a mismatch; the clock test needs about 23000 cycles.
  initial begin
    repeat (40000) @(posedge aclk);
    fail_count++;
    $display("unexpected at %0t: timeout", $time);
    conclude();
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, debug_halt, peers, slow_run} = '0;
    wstrb = 4'hF;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    expect_reg(`OFS_CFG, 32'h0);
    expect_reg(`OFS_CTL, 32'h0);
    expect_reg(`OFS_AR, 32'hFFFF_FFFF);
    expect_reg(`OFS_BILR, 32'h0000_FFFF);
    expect_reg(`OFS_APR, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      peers <= 2'($random(seed));
      @(negedge aclk);
      chk(32'(adc_trigger), 32'(|peers));
      @(posedge aclk);
    end
    peers <= 2'h0;
    wr(`OFS_AILR, 32'h0001_0003);
    expect_reg(`OFS_BILR, join_halves(16'h0, 16'h0001));
    n = 3 + ($random(seed) & 7);
    wr(`OFS_AMR, 32'h1);
    wr(`OFS_IMR, 32'h1);
    wr(`OFS_CTL, 32'h21);
    wr(`OFS_AILR, n);
    watch_trig(60);
    chk(32'(seen), 32'h1);
    expect_reg(`OFS_CTL, 32'h20);
    expect_reg(`OFS_RIS, 32'h1);
    expect_reg(`OFS_MIS, 32'h1);
    chk(32'(timer_irq), 32'h1);
    wr(`OFS_ICR, 32'h0);
    expect_reg(`OFS_RIS, 32'h1);
    wr(`OFS_ICR, 32'h1);
    expect_reg(`OFS_RIS, 32'h0);
    $display("test one-shot done");
    wr(`OFS_AMR, 32'h2);
    wr(`OFS_BMR, 32'h1);
    wr(`OFS_CTL, 32'h1);
    watch_trig(60);
    chk(32'(seen), 32'h0);
    expect_reg(`OFS_RIS, 32'h1);
    expect_reg(`OFS_CTL, 32'h1);
    $display("test periodic done");
    wr(`OFS_CTL, 32'h3);
    debug_halt <= 1'b1;
    wr(`OFS_AILR, 32'h0000_0100);
    expect_reg(`OFS_AR, 32'h100);
    expect_reg(`OFS_AR, 32'h100);
    debug_halt <= 1'b0;
    repeat (3) @(posedge aclk);
    expect_reg(`OFS_AR, 32'h0000_00FD);
    chk(32'(rd != 32'h100), 32'h1);
    wr(`OFS_CTL, 32'h0);
    $display("test stall done");
    wr(`OFS_CFG, 32'h1);
    expect_reg(`OFS_AR, 32'h1);
    wr(`OFS_AMATCH, 32'h2);
    wr(`OFS_ICR, 32'h109);
    wr(`OFS_IMR, 32'h8);
    wr(`OFS_CTL, 32'h13);
    debug_halt <= 1'b1;
    slow_run <= 1'b1;
    n = 0;
    while (timer_irq !== 1'b1 && n < 30000) begin
      @(negedge aclk);
      n++;
    end
    @(posedge aclk);
    chk(32'(timer_irq), 32'h1);
    expect_reg(`OFS_AR, 32'h0);
    expect_reg(`OFS_MIS, 32'h8);
    wr(`OFS_ICR, 32'h8);
    expect_reg(`OFS_RIS, 32'h0);
    chk(32'(timer_irq), 32'h0);
    slow_run <= 1'b0;
    $display("test clock done");
    wr(`OFS_CTL, 32'h0);
    wr(`OFS_CFG, 32'h4);
    wr(`OFS_AILR, 32'h0005_0007);
    expect_reg(`OFS_AILR, 32'h7);
    expect_reg(`OFS_BILR, 32'h0);
    wr(`OFS_BMR, 32'h2);
    wr(`OFS_BILR, 32'h3);
    wr(`OFS_IMR, 32'h100);
    wr(`OFS_CTL, 32'h2100);
    watch_trig(20);
    chk(32'(seen), 32'h1);
    expect_reg(`OFS_RIS, 32'h100);
    expect_reg(`OFS_CTL, 32'h2100);
    wr(`OFS_CTL, 32'h0);
    $display("test split done");
    wr(8'h40, 32'h0);
    chk(32'(resp), 32'(`RESP_SLVERR));
    expect_reg(8'h44, 32'h0);
    chk(32'(resp), 32'(`RESP_SLVERR));
    $display("test unmapped done");
    conclude();
  end
endmodule // general_timer_block_tb_top
